// File: hw/synth_cfg_pkg.sv
package synth_cfg_pkg;
  // register offsets
  localparam logic [7:0] OFS_IO_UPDATE = 8'h05;
  localparam logic [7:0] OFS_OSC_CONTROL = 8'h0e;
  localparam logic [7:0] OFS_OSC_AMPLITUDE = 8'h0f;
  localparam logic [7:0] OFS_OSC_BAND = 8'h10;
  localparam logic [7:0] OFS_FEEDBACK_INTEGER = 8'h11;
  localparam logic [7:0] OFS_MODULUS_HIGH = 8'h12;
  localparam logic [7:0] OFS_MODULUS_MID = 8'h13;
  localparam logic [7:0] OFS_MODULUS_LOW_LOOP_CTRL = 8'h14;
  localparam logic [7:0] OFS_FRACTION_HIGH = 8'h15;
  localparam logic [7:0] OFS_FRACTION_MID = 8'h16;
  localparam logic [7:0] OFS_FRACTION_LOW_DIVIDER_MSB = 8'h17;
  localparam logic [7:0] OFS_SECONDARY_DIVIDERS = 8'h18;
  localparam logic [7:0] OFS_DIVIDER_OVERRIDE = 8'h19;
  localparam logic [7:0] OFS_RECEIVER_BANDGAP = 8'h1a;
  localparam logic [7:0] OFS_CRYSTAL_TUNING = 8'h1b;
  localparam logic [7:0] OFS_SPARE_1C = 8'h1c;
  localparam logic [7:0] OFS_REFERENCE_SELECT = 8'h1d;
  localparam logic [7:0] OFS_PRIMARY_DRIVER_CTRL = 8'h32;
  localparam logic [7:0] OFS_SECONDARY_SOURCE_SELECT = 8'h33;
  localparam logic [7:0] OFS_SECONDARY_DRIVER_CTRL = 8'h34;
  // reset values
  localparam logic [7:0] RST_OSC_CONTROL = 8'h70;
  localparam logic [7:0] RST_OSC_AMPLITUDE = 8'h80;
  localparam logic [7:0] RST_OSC_BAND = 8'h80;
  localparam logic [7:0] RST_FEEDBACK_INTEGER = 8'h00;
  localparam logic [7:0] RST_MODULUS_HIGH = 8'h80;
  localparam logic [7:0] RST_MODULUS_MID = 8'h00;
  localparam logic [7:0] RST_MODULUS_LOW_LOOP_CTRL = 8'h00;
  localparam logic [7:0] RST_FRACTION_HIGH = 8'h20;
  localparam logic [7:0] RST_FRACTION_MID = 8'h00;
  localparam logic [7:0] RST_FRACTION_LOW_DIVIDER_MSB = 8'h01;
  localparam logic [7:0] RST_SECONDARY_DIVIDERS = 8'h00;
  localparam logic [7:0] RST_DIVIDER_OVERRIDE = 8'h20;
  localparam logic [7:0] RST_RECEIVER_BANDGAP = 8'h00;
  localparam logic [7:0] RST_CRYSTAL_TUNING = 8'h80;
  localparam logic [7:0] RST_REFERENCE_SELECT = 8'h00;
  localparam logic [7:0] RST_PRIMARY_DRIVER_CTRL = 8'h80;
  localparam logic [7:0] RST_SECONDARY_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_SECONDARY_DRIVER_CTRL = 8'h80;
  // field positions
  localparam int BIT_UPDATE = 0;
  localparam int BIT_CALIBRATE = 7;
  localparam int BIT_LEVEL_AUTO = 6;
  localparam int BIT_CAL_OVERRIDE = 2;
  localparam int BIT_BAND_OVERRIDE = 0;
  localparam int BIT_FREQ_OVERRIDE = 3;
  localparam int BIT_MOD_BYPASS = 2;
  localparam int BIT_MOD_DISABLE = 1;
  localparam int BIT_LOOP_RESET = 0;
  localparam int BIT_DIV_OVERRIDE = 7;
  localparam int BIT_RX_RESET = 7;
  localparam int BIT_BANDGAP_OVERRIDE = 0;
  localparam int BIT_TUNE_DISABLE = 7;
  localparam int BIT_FORCE_CRYSTAL = 0;
  localparam int BIT_SECOND_SOURCE = 3;
  localparam logic [2:0] PRESCALE_BASE = 3'h4;
  // serial frame: 16 instruction bits then 8 data bits
  localparam int FRAME_BITS = 24;
  localparam int BIT_READ = 15;
  localparam logic [4:0] CNT_INSTR_END = 5'h0f;
  localparam logic [4:0] CNT_FRAME_END = 5'h17;
  typedef enum logic [1:0] {IDLE_ST, INSTR_ST, DATA_ST, DONE_ST} serial_state_type;
endpackage

// File: hw/synth_cfg_regs.sv
`timescale 1ns/1ns
// Operation
// [R01] calibrate bit starts calibration, self-clears, needs override
// [R02] auto level on by default, else amplitude field
// [R03] three-bit level threshold, reset code 110
// [R04] calibration automatic unless override set
// [R05] band automatic unless override, band field 1000000
// [R06] six-bit amplitude, reset 100000, manual only
// [R07] host keeps integer divide word at least 64
// [R08] twenty-bit modulus from three registers, reset 524288
// [R09] twenty-bit fraction split alike, reset 131072
// [R10] frequency from pins unless override set
// [R11] bypass bit restricts to integer division
// [R12] disable bit stops modulator clocks
// [R13] loop reset holds counters, dividers unaffected
// [R14] host writes zeros to unused fraction bits
// [R15] host keeps secondary divider between 1 and 63
// [R16] prescale ratio equals code plus four
// [R17] dividers follow straps unless override set
// [R18] receiver reset bit pulses then self-clears
// [R19] bandgap field only with bandgap override
// [R20] tuning automatic unless disable cleared, inverted code
// [R21] force bit selects crystal over external reference
// [R22] source bit picks divider or reference for output
// [R23] buffered writes apply on self-clearing update bit
// [R24] self-clearing bits read zero after launch
module synth_cfg_regs
  import synth_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // 3-wire serial port (sdio split into three signals)
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // straps and status from the analog side
  input wire logic [3:0] freq_select_pins,
  input wire logic [5:0] divider_strap_pins,
  input wire logic ext_reference_present,
  // oscillator controls
  output logic osc_cal_start,
  output logic osc_cal_auto,
  output logic auto_level_control,
  output logic [5:0] osc_amplitude_manual,
  output logic [2:0] level_threshold,
  output logic osc_band_auto,
  output logic [6:0] osc_band_manual,
  // feedback divider controls
  output logic freq_from_regs,
  output logic [3:0] freq_select,
  output logic [7:0] feedback_integer_word,
  output logic [19:0] modulus_word,
  output logic [19:0] fraction_word,
  output logic integer_only,
  output logic modulator_clock_stop,
  output logic loop_reset,
  // secondary output dividers
  output logic [5:0] secondary_divider,
  output logic [3:0] prescale_ratio,
  // receiver, crystal and output source
  output logic receiver_reset,
  output logic bandgap_manual,
  output logic [4:0] bandgap_adjust,
  output logic tuning_auto,
  output logic [5:0] crystal_tuning_cap,
  output logic use_crystal_input,
  output logic second_output_from_reference
);

  localparam int NREG = 18;
  // reset image, highest index first so it lines up with the packed register arrays
  localparam logic [NREG-1:0][7:0] REG_RST = {RST_SECONDARY_DRIVER_CTRL, RST_SECONDARY_SOURCE_SELECT,
    RST_PRIMARY_DRIVER_CTRL, RST_REFERENCE_SELECT, RST_CRYSTAL_TUNING, RST_RECEIVER_BANDGAP,
    RST_DIVIDER_OVERRIDE, RST_SECONDARY_DIVIDERS, RST_FRACTION_LOW_DIVIDER_MSB, RST_FRACTION_MID,
    RST_FRACTION_HIGH, RST_MODULUS_LOW_LOOP_CTRL, RST_MODULUS_MID, RST_MODULUS_HIGH,
    RST_FEEDBACK_INTEGER, RST_OSC_BAND, RST_OSC_AMPLITUDE, RST_OSC_CONTROL};
  localparam int I_OSC = 0;
  localparam int I_AMP = 1;
  localparam int I_BAND = 2;
  localparam int I_INT = 3;
  localparam int I_MODH = 4;
  localparam int I_MODM = 5;
  localparam int I_MODL = 6;
  localparam int I_FRH = 7;
  localparam int I_FRM = 8;
  localparam int I_FRL = 9;
  localparam int I_SDIV = 10;
  localparam int I_DOVR = 11;
  localparam int I_RXBG = 12;
  localparam int I_XTUNE = 13;
  localparam int I_REFSEL = 14;
  localparam int I_DRV1 = 15;
  localparam int I_SRC = 16;
  localparam int I_DRV2 = 17;

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] din_sync;
    logic [1:0][3:0] freq_sync;
    logic [1:0][5:0] strap_sync;
    logic [1:0] ref_sync;
    serial_state_type state;
    logic [4:0] bit_cnt;
    logic [15:0] instr;
    logic [7:0] shift;
    logic [NREG-1:0][7:0] buffer;
    logic [NREG-1:0][7:0] active;
    logic sdo;
    logic sdo_oe;
    logic cal_pulse;
    logic rx_pulse;
  } state_type;

  state_type state_reg, state_next;
  logic [7:0] rd_data;
  logic [4:0] rd_index;
  logic rd_hit;
  logic [7:0] sel_addr;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_active;

  // edge detect uses only the second and third sync stages
  assign sclk_rise = state_reg.sclk_sync[1] & ~state_reg.sclk_sync[2];
  assign sclk_fall = ~state_reg.sclk_sync[1] & state_reg.sclk_sync[2];
  assign frame_active = ~state_reg.cs_sync[1];
  assign sel_addr = state_reg.instr[7:0];

  // address decode: readback shows the active registers, unmapped reads zero
  always_comb begin
    rd_hit = 1'b1;
    rd_index = '0;
    if (sel_addr == OFS_OSC_CONTROL) begin
      rd_index = 5'(I_OSC);
    end else if (sel_addr == OFS_OSC_AMPLITUDE) begin
      rd_index = 5'(I_AMP);
    end else if (sel_addr == OFS_OSC_BAND) begin
      rd_index = 5'(I_BAND);
    end else if (sel_addr == OFS_FEEDBACK_INTEGER) begin
      rd_index = 5'(I_INT);
    end else if (sel_addr == OFS_MODULUS_HIGH) begin
      rd_index = 5'(I_MODH);
    end else if (sel_addr == OFS_MODULUS_MID) begin
      rd_index = 5'(I_MODM);
    end else if (sel_addr == OFS_MODULUS_LOW_LOOP_CTRL) begin
      rd_index = 5'(I_MODL);
    end else if (sel_addr == OFS_FRACTION_HIGH) begin
      rd_index = 5'(I_FRH);
    end else if (sel_addr == OFS_FRACTION_MID) begin
      rd_index = 5'(I_FRM);
    end else if (sel_addr == OFS_FRACTION_LOW_DIVIDER_MSB) begin
      rd_index = 5'(I_FRL);
    end else if (sel_addr == OFS_SECONDARY_DIVIDERS) begin
      rd_index = 5'(I_SDIV);
    end else if (sel_addr == OFS_DIVIDER_OVERRIDE) begin
      rd_index = 5'(I_DOVR);
    end else if (sel_addr == OFS_RECEIVER_BANDGAP) begin
      rd_index = 5'(I_RXBG);
    end else if (sel_addr == OFS_CRYSTAL_TUNING) begin
      rd_index = 5'(I_XTUNE);
    end else if (sel_addr == OFS_REFERENCE_SELECT) begin
      rd_index = 5'(I_REFSEL);
    end else if (sel_addr == OFS_PRIMARY_DRIVER_CTRL) begin
      rd_index = 5'(I_DRV1);
    end else if (sel_addr == OFS_SECONDARY_SOURCE_SELECT) begin
      rd_index = 5'(I_SRC);
    end else if (sel_addr == OFS_SECONDARY_DRIVER_CTRL) begin
      rd_index = 5'(I_DRV2);
    end else begin
      rd_hit = 1'b0; // spare and unmapped offsets take no write and read zero
    end
    if (rd_hit) begin
      rd_data = state_reg.active[rd_index];
    end else begin
      rd_data = 8'h00;
    end
  end

  // serial engine, buffer writes and the update transfer
  always_comb begin
    state_next = state_reg;
    state_next.sclk_sync = {state_reg.sclk_sync[1:0], sclk};
    state_next.cs_sync = {state_reg.cs_sync[0], cs_n};
    state_next.din_sync = {state_reg.din_sync[0], sdio_in};
    // straps are pins as well: two stages before any decode reads them
    state_next.freq_sync = {state_reg.freq_sync[0], freq_select_pins};
    state_next.strap_sync = {state_reg.strap_sync[0], divider_strap_pins};
    state_next.ref_sync = {state_reg.ref_sync[0], ext_reference_present};
    state_next.cal_pulse = 1'b0;
    state_next.rx_pulse = 1'b0;
    if (!frame_active) begin
      state_next.state = IDLE_ST;
      state_next.sdo_oe = 1'b0;
      state_next.bit_cnt = '0;
    end else begin
      case (state_reg.state)
        IDLE_ST: begin
          state_next.state = INSTR_ST;
          state_next.bit_cnt = '0;
        end
        INSTR_ST: begin
          if (sclk_rise) begin
            state_next.instr = {state_reg.instr[14:0], state_reg.din_sync[1]};
            state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
            if (state_reg.bit_cnt == CNT_INSTR_END) begin
              state_next.state = DATA_ST;
            end
          end
        end
        DATA_ST: begin
          // read data shifts out on falling edges, msb first
          if (state_reg.instr[BIT_READ] && sclk_fall) begin
            state_next.sdo_oe = 1'b1;
            state_next.sdo = state_reg.shift[7];
          end
          if (sclk_rise) begin
            if (state_reg.instr[BIT_READ]) begin
              if (state_reg.bit_cnt == CNT_INSTR_END + 5'h01) begin
                state_next.shift = {rd_data[6:0], 1'b0};
                state_next.sdo = rd_data[7];
              end else begin
                state_next.shift = {state_reg.shift[6:0], 1'b0};
              end
            end else begin
              state_next.shift = {state_reg.shift[6:0], state_reg.din_sync[1]};
            end
            state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
            if (state_reg.bit_cnt == CNT_FRAME_END) begin
              state_next.state = DONE_ST;
            end
          end
          if (state_reg.instr[BIT_READ] && state_reg.bit_cnt == CNT_INSTR_END + 5'h01 && !sclk_rise) begin
            state_next.sdo = rd_data[7];
            state_next.sdo_oe = 1'b1;
          end
        end
        DONE_ST: begin
          // commit the written byte once, then return to the instruction phase for a further frame
          state_next.state = INSTR_ST;
          state_next.bit_cnt = '0;
          state_next.sdo_oe = 1'b0;
          if (!state_reg.instr[BIT_READ]) begin
            if (sel_addr == OFS_IO_UPDATE) begin
              if (state_reg.shift[BIT_UPDATE]) begin
                state_next.active = state_reg.buffer; // R23
                // self-clearing bits launch a pulse (calibrate only with its override set) and never stay set
                state_next.cal_pulse = state_reg.buffer[I_OSC][BIT_CALIBRATE]
                  & state_reg.buffer[I_OSC][BIT_CAL_OVERRIDE]; // R01 R04
                state_next.rx_pulse = state_reg.buffer[I_RXBG][BIT_RX_RESET]; // R18
                state_next.active[I_OSC][BIT_CALIBRATE] = 1'b0; // R24
                state_next.active[I_RXBG][BIT_RX_RESET] = 1'b0; // R24
                state_next.buffer[I_OSC][BIT_CALIBRATE] = 1'b0; // R24
                state_next.buffer[I_RXBG][BIT_RX_RESET] = 1'b0; // R24
              end
            end else if (rd_hit) begin
              state_next.buffer[rd_index] = state_reg.shift;
            end
          end
        end
        default: begin
          state_next.state = IDLE_ST;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // constants only, so the asynchronous path carries no decode logic
      state_reg <= '0;
      state_reg.state <= IDLE_ST;
      state_reg.cs_sync <= 2'h3; // frame select idles high
      state_reg.ref_sync <= 2'h3; // assume a reference until the pin says otherwise
      state_reg.buffer <= REG_RST;
      state_reg.active <= REG_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // registered outputs decoded from the active image and the synchronised pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      osc_cal_start <= 1'b0;
      osc_cal_auto <= 1'b1;
      auto_level_control <= 1'b1;
      osc_amplitude_manual <= '0;
      level_threshold <= '0;
      osc_band_auto <= 1'b1;
      osc_band_manual <= '0;
      freq_from_regs <= 1'b0;
      freq_select <= '0;
      feedback_integer_word <= '0;
      modulus_word <= '0;
      fraction_word <= '0;
      integer_only <= 1'b0;
      modulator_clock_stop <= 1'b0;
      loop_reset <= 1'b0;
      secondary_divider <= '0;
      prescale_ratio <= '0;
      receiver_reset <= 1'b0;
      bandgap_manual <= 1'b0;
      bandgap_adjust <= '0;
      tuning_auto <= 1'b1;
      crystal_tuning_cap <= '0;
      use_crystal_input <= 1'b0;
      second_output_from_reference <= 1'b0;
    end else begin
      sdio_out <= state_reg.sdo;
      sdio_oe <= state_reg.sdo_oe;
      osc_cal_start <= state_reg.cal_pulse; // R01
      osc_cal_auto <= ~state_reg.active[I_OSC][BIT_CAL_OVERRIDE]; // R04
      auto_level_control <= state_reg.active[I_OSC][BIT_LEVEL_AUTO]; // R02
      osc_amplitude_manual <= state_reg.active[I_AMP][7:2]; // R06
      level_threshold <= state_reg.active[I_OSC][5:3]; // R03
      osc_band_auto <= ~state_reg.active[I_OSC][BIT_BAND_OVERRIDE]; // R05
      osc_band_manual <= state_reg.active[I_BAND][7:1]; // R05
      freq_from_regs <= state_reg.active[I_MODL][BIT_FREQ_OVERRIDE]; // R10
      freq_select <= state_reg.freq_sync[1]; // synchronised pins, three cycles behind
      feedback_integer_word <= state_reg.active[I_INT];
      modulus_word <= {state_reg.active[I_MODH], state_reg.active[I_MODM],
        state_reg.active[I_MODL][7:4]}; // R08
      fraction_word <= {state_reg.active[I_FRH], state_reg.active[I_FRM],
        state_reg.active[I_FRL][7:4]}; // R09
      integer_only <= state_reg.active[I_MODL][BIT_MOD_BYPASS]; // R11
      modulator_clock_stop <= state_reg.active[I_MODL][BIT_MOD_DISABLE]; // R12
      loop_reset <= state_reg.active[I_MODL][BIT_LOOP_RESET]; // R13
      // strap decode: upper three pins divider bits, lower three prescale code
      if (state_reg.active[I_DOVR][BIT_DIV_OVERRIDE]) begin
        secondary_divider <= {state_reg.active[I_FRL][0], state_reg.active[I_SDIV][7:3]}; // R17
        prescale_ratio <= {1'b0, state_reg.active[I_SDIV][2:0]} + {1'b0, PRESCALE_BASE}; // R16
      end else begin
        secondary_divider <= {3'h0, state_reg.strap_sync[1][5:3]}; // R17
        prescale_ratio <= {1'b0, state_reg.strap_sync[1][2:0]} + {1'b0, PRESCALE_BASE}; // R16
      end
      receiver_reset <= state_reg.rx_pulse; // R18
      bandgap_manual <= state_reg.active[I_RXBG][BIT_BANDGAP_OVERRIDE]; // R19
      bandgap_adjust <= state_reg.active[I_RXBG][6:2]; // R19
      tuning_auto <= state_reg.active[I_XTUNE][BIT_TUNE_DISABLE]; // R20
      crystal_tuning_cap <= ~state_reg.active[I_XTUNE][5:0]; // R20
      use_crystal_input <= state_reg.active[I_REFSEL][BIT_FORCE_CRYSTAL]
        | ~state_reg.ref_sync[1]; // R21
      second_output_from_reference <= state_reg.active[I_SRC][BIT_SECOND_SOURCE]; // R22
    end
  end

endmodule

// File: sim/synth_cfg_host.sv
`timescale 1ns/1ns
module synth_cfg_host (
  // system clock paces the serial edges
  input wire logic clk_sys,
  // 3-wire port
  output logic sclk,
  output logic cs_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  // idle frame levels at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_in = 1'b0;
  end
  // six system cycles per serial phase keeps clear of the synchroniser minimum
  task automatic half();
    repeat (6) @(negedge clk_sys);
  endtask
  // one 24-bit frame msb first; read bits sampled just before each rise
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] frame;
    frame = {rd, 7'h00, a, d};
    cs_n = 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      sdio_in = frame[i];
      half();
      if (i < 8) q[i] = (rd && !sdio_oe) ? 1'bx : sdio_out; // an undriven line reads unknown
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    sdio_in = ~sdio_in;
    half();
  endtask
endmodule

// File: sim/synth_cfg_regs_asserts.sv
`timescale 1ns/1ns
module synth_cfg_regs_chk (
  // clock, reset and frame select
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  // straps
  input wire logic ext_reference_present,
  input wire logic [3:0] freq_select_pins,
  // decoded controls
  input wire logic osc_cal_start,
  input wire logic osc_cal_auto,
  input wire logic receiver_reset,
  input wire logic use_crystal_input,
  input wire logic [3:0] prescale_ratio,
  input wire logic [3:0] freq_select,
  input wire logic [19:0] modulus_word,
  input wire logic [19:0] fraction_word
);
  logic [3:0] idle_reg;
  logic [3:0] idle_next;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // cycles since the frame closed; saturates so a long idle never wraps to zero
  always_comb begin
    idle_next = (idle_reg == 4'hf) ? idle_reg : idle_reg + 4'h1;
    if (!cs_n) begin
      idle_next = 4'h0;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_reg <= 4'h0;
    end else begin
      idle_reg <= idle_next;
    end
  end
  chk_cal_pulse_single: assert property (osc_cal_start |=> !osc_cal_start)
    else $error("calibrate pulse longer than one cycle");
  chk_rx_pulse_single: assert property (receiver_reset |=> !receiver_reset)
    else $error("receiver reset pulse longer than one cycle");
  chk_cal_needs_override: assert property (osc_cal_start |-> ##[0:1] !osc_cal_auto)
    else $error("calibration launched while automatic");
  chk_crystal_without_ref: assert property (!ext_reference_present [*4] |-> use_crystal_input)
    else $error("crystal not used without reference");
  chk_prescale_in_range: assert property (!$past(rst) |-> prescale_ratio inside {[4'h4:4'hb]})
    else $error("prescale ratio out of range");
  chk_freq_follows_pins: assert property (!$past(rst, 3) |-> freq_select == $past(freq_select_pins, 3))
    else $error("frequency select does not follow pins");
  chk_words_hold_idle: assert property (idle_reg > 4'h8 |-> $stable(modulus_word) && $stable(fraction_word))
    else $error("divider words changed without a frame");
  chk_pulse_in_frame: assert property (osc_cal_start || receiver_reset |-> idle_reg < 4'h8)
    else $error("action pulse without an update frame");
endmodule
bind synth_cfg_regs synth_cfg_regs_chk chk_u (.clk_sys, .rst, .cs_n, .ext_reference_present, .freq_select_pins,
  .osc_cal_start, .osc_cal_auto, .receiver_reset, .use_crystal_input, .prescale_ratio, .freq_select,
  .modulus_word, .fraction_word);

// File: sim/tb_synth_pll_config_regs.sv
`timescale 1ns/1ns
module tb_synth_pll_config_regs;
  import synth_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdio_in, sdio_out, sdio_oe;
  logic [3:0] freq_select_pins = 4'ha;
  logic [5:0] divider_strap_pins = 6'h28;
  logic ext_reference_present = 1'b1;
  logic osc_cal_start, osc_cal_auto, auto_level_control, osc_band_auto, freq_from_regs, integer_only;
  logic modulator_clock_stop, loop_reset, receiver_reset, bandgap_manual, tuning_auto, use_crystal_input;
  logic second_output_from_reference;
  logic [5:0] osc_amplitude_manual, secondary_divider, crystal_tuning_cap;
  logic [2:0] level_threshold;
  logic [6:0] osc_band_manual;
  logic [3:0] freq_select, prescale_ratio;
  logic [4:0] bandgap_adjust;
  logic [7:0] feedback_integer_word, rdat;
  logic [19:0] modulus_word, fraction_word;
  int bad_count = 0;
  int tests_run = 0;
  int cal_pulses = 0;
  int rx_pulses = 0;
  always #10 clk_sys = ~clk_sys;
  synth_cfg_regs dut_u (.clk_sys, .rst, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .freq_select_pins,
    .divider_strap_pins, .ext_reference_present, .osc_cal_start, .osc_cal_auto, .auto_level_control,
    .osc_amplitude_manual, .level_threshold, .osc_band_auto, .osc_band_manual, .freq_from_regs, .freq_select,
    .feedback_integer_word, .modulus_word, .fraction_word, .integer_only, .modulator_clock_stop, .loop_reset,
    .secondary_divider, .prescale_ratio, .receiver_reset, .bandgap_manual, .bandgap_adjust, .tuning_auto,
    .crystal_tuning_cap, .use_crystal_input, .second_output_from_reference);
  synth_cfg_host host_u (.clk_sys, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe);
  // count one-cycle action pulses so a stretched or missing one shows up
  always @(posedge clk_sys) begin
    if (osc_cal_start === 1'b1) cal_pulses++;
    if (receiver_reset === 1'b1) rx_pulses++;
  end
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, rdat);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_u.xfer(1'b1, a, 8'h00, rdat);
    cmp(20'(rdat), 20'(exp));
  endtask
  // copy the buffered image into the active controls
  task automatic upd();
    wr(OFS_IO_UPDATE, 8'h01);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // defaults at the ports and in readback, plus an unmapped read
  task automatic t_defaults();
    logic [7:0] ofs [6] = '{8'h0e, 8'h0f, 8'h12, 8'h17, 8'h1b, 8'h20};
    logic [7:0] exp [6] = '{8'h70, 8'h80, 8'h80, 8'h01, 8'h80, 8'h00};
    cmp(modulus_word, 20'h80000);
    cmp(fraction_word, 20'h20000);
    cmp(20'({auto_level_control, osc_cal_auto, osc_band_auto, tuning_auto}), 20'hf);
    cmp(20'({level_threshold, osc_amplitude_manual, osc_band_manual}), 20'({3'h6, 6'h20, 7'h40}));
    cmp(20'({freq_from_regs, integer_only, modulator_clock_stop, loop_reset, second_output_from_reference}), 20'h0);
    cmp(20'({freq_select, secondary_divider, prescale_ratio}), 20'({4'ha, 6'h05, 4'h4}));
    foreach (ofs[i]) rd(ofs[i], exp[i]);
    freq_select_pins = 4'h5;
    repeat (3) @(negedge clk_sys);
    cmp(20'(freq_select), 20'h5);
  endtask
  // divider words are buffered until update, then assemble from three registers
  task automatic t_words();
    wr(OFS_FEEDBACK_INTEGER, 8'h40);
    wr(OFS_MODULUS_HIGH, 8'hf1);
    wr(OFS_MODULUS_MID, 8'h23);
    wr(OFS_MODULUS_LOW_LOOP_CTRL, 8'h5f);
    wr(OFS_FRACTION_HIGH, 8'h0e);
    wr(OFS_FRACTION_MID, 8'hdc);
    wr(OFS_FRACTION_LOW_DIVIDER_MSB, 8'hb1);
    wr(OFS_SECONDARY_DIVIDERS, 8'hff);
    wr(OFS_DIVIDER_OVERRIDE, 8'h80);
    cmp(modulus_word, 20'h80000);
    upd();
    cmp(20'(feedback_integer_word), 20'h40);
    cmp(modulus_word, 20'hf1235);
    cmp(fraction_word, 20'h0edcb);
    cmp(20'({freq_from_regs, integer_only, modulator_clock_stop, loop_reset}), 20'hf);
    cmp(20'({secondary_divider, prescale_ratio}), 20'({6'h3f, 4'hb}));
    rd(OFS_MODULUS_LOW_LOOP_CTRL, 8'h5f);
    rd(OFS_IO_UPDATE, 8'h00);
    wr(OFS_DIVIDER_OVERRIDE, 8'h00);
    upd();
    cmp(20'({secondary_divider, prescale_ratio}), 20'({6'h05, 4'h4}));
  endtask
  // calibrate twice with override, then once without it
  task automatic t_osc();
    wr(OFS_OSC_AMPLITUDE, 8'hfc);
    wr(OFS_OSC_BAND, 8'h02);
    repeat (2) begin
      wr(OFS_OSC_CONTROL, 8'h84);
      upd();
    end
    cmp(20'(cal_pulses), 20'h2);
    cmp(20'({auto_level_control, osc_cal_auto, osc_band_auto, level_threshold}), 20'h1 << 3);
    cmp(20'({osc_amplitude_manual, osc_band_manual}), 20'({6'h3f, 7'h01}));
    rd(OFS_OSC_CONTROL, 8'h04);
    wr(OFS_OSC_CONTROL, 8'hb9);
    upd();
    cmp(20'(cal_pulses), 20'h2);
    cmp(20'({osc_cal_auto, osc_band_auto, level_threshold}), 20'({2'b10, 3'h7}));
  endtask
  // receiver reset, bandgap, tuning code, reference and source select
  task automatic t_rx();
    wr(OFS_RECEIVER_BANDGAP, 8'hfd);
    wr(OFS_CRYSTAL_TUNING, 8'h3e);
    wr(OFS_REFERENCE_SELECT, 8'h01);
    wr(OFS_SECONDARY_SOURCE_SELECT, 8'h08);
    upd();
    cmp(20'(rx_pulses), 20'h1);
    cmp(20'({bandgap_manual, bandgap_adjust, tuning_auto, crystal_tuning_cap}), 20'({6'h3f, 7'h01}));
    cmp(20'({use_crystal_input, second_output_from_reference}), 20'h3);
    rd(OFS_RECEIVER_BANDGAP, 8'h7d);
    wr(OFS_REFERENCE_SELECT, 8'h00);
    upd();
    cmp(20'(use_crystal_input), 20'h0);
    ext_reference_present = 1'b0;
    repeat (3) @(negedge clk_sys);
    cmp(20'(use_crystal_input), 20'h1);
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_defaults();
    t_words();
    t_osc();
    t_rx();
    summarize();
  end
  // about 40 frames of some 320 cycles each; allow plenty beyond that
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
endmodule
